// [fsch_handler.sv]
// Settings command handler: decodes reports, holds settings, drives pins.
// Assumes the host strobes a full report in i_cmd with i_cmd_valid;
// nonvolatile storage sits outside and is written via o_nv_* strobe.
`timescale 1ns/1ps
`default_nettype none
module fsch_handler
    import fsch_pkg::*;
#(
    parameter logic [63:0] FACTORY_SERIAL = 64'h3132333435363738
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_cmd_valid,
    input wire logic [REPORT_BITS-1:0] i_cmd,
    input wire logic [23:0] i_nv_boot,
    input wire logic i_unlocked,
    input wire logic i_rx_busy,
    input wire logic i_tx_busy,
    input wire logic i_i2c_busy,
    input wire logic i_i2c_pin_en,
    input wire logic i_suspended,
    input wire logic i_sus_pin_en,
    input wire logic i_configured,
    input wire logic i_cfg_pin_en,
    input wire logic i_clkout_en,
    output logic o_rsp_valid,
    output logic [REPORT_BITS-1:0] o_rsp,
    output logic o_nv_we,
    output logic [7:0] o_nv_sub,
    output logic [495:0] o_nv_data,
    output logic o_serial_enum_en,
    output logic o_rx_indicator,
    output logic o_tx_indicator,
    output logic o_i2c_indicator,
    output logic o_suspend_indicator,
    output logic o_configured_indicator,
    output logic [1:0] o_security,
    output logic o_clk_out,
    output logic [1:0] o_dac_ref_level,
    output logic o_dac_ref_vdd,
    output logic [4:0] o_dac_code
);
    fsch_cfg_t cfg_r;
    fsch_cfg_t cfg_nxt;
    fsch_act_t act_s1_r;
    fsch_act_t act_r;
    logic boot_r;
    logic boot_nxt;
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    logic [REPORT_BITS-1:0] rsp_r;
    logic [REPORT_BITS-1:0] rsp_nxt;
    logic nv_we_r;
    logic nv_we_nxt;
    logic [7:0] nv_sub_r;
    logic [7:0] nv_sub_nxt;
    logic [495:0] nv_data_r;
    logic [495:0] nv_data_nxt;
    logic [5:0] ind_r;
    logic [5:0] ind_nxt;
    logic [7:0] c_code;
    logic [7:0] c_sub;
    logic [7:0] c_flags;
    logic [7:0] c_div;
    logic [7:0] c_dac;
    logic [7:0] b_flags;
    logic [7:0] b_div;
    logic [7:0] b_dac;
    logic clk_pin;

    // Byte views of the incoming report and boot image
    assign c_code = i_cmd[BYTE_CODE*8 +: 8];
    assign c_sub = i_cmd[BYTE_STATUS*8 +: 8];
    assign c_flags = i_cmd[BYTE_FLAGS*8 +: 8];
    assign c_div = i_cmd[BYTE_CLKDIV*8 +: 8];
    assign c_dac = i_cmd[BYTE_DAC*8 +: 8];
    assign b_flags = i_nv_boot[7:0];
    assign b_div = i_nv_boot[15:8];
    assign b_dac = i_nv_boot[23:16];

    // Activity inputs come from other domains and pins
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            act_s1_r <= '0;
            act_r <= '0;
        end
        else
        begin
            act_s1_r <= {i_rx_busy, i_tx_busy, i_i2c_busy, i_i2c_pin_en,
                         i_suspended, i_sus_pin_en, i_configured, i_cfg_pin_en};
            act_r <= act_s1_r;
        end
    end

    // Command decode, settings update and response forming
    always_comb
    begin
        cfg_nxt = cfg_r;
        boot_nxt = 1'b0;
        rsp_valid_nxt = 1'b0;
        rsp_nxt = rsp_r;
        nv_we_nxt = 1'b0;
        nv_sub_nxt = nv_sub_r;
        nv_data_nxt = nv_data_r;
        if (boot_r)
        begin
            // Apply stored settings once after reset release
            cfg_nxt.serial_enum_en = b_flags[BIT_SER_EN];
            cfg_nxt.rx_idle = b_flags[BIT_RX_IDLE];
            cfg_nxt.tx_idle = b_flags[BIT_TX_IDLE];
            cfg_nxt.i2c_idle = b_flags[BIT_I2C_IDLE];
            cfg_nxt.sus_idle = b_flags[BIT_SUS_IDLE];
            cfg_nxt.cfg_idle = b_flags[BIT_CFG_IDLE];
            cfg_nxt.security = fsch_sec_t'(b_flags[1:0]);
            cfg_nxt.clk_div = b_div[4:0];
            cfg_nxt.dac_ref_level = b_dac[7:6];
            cfg_nxt.dac_ref_vdd = b_dac[BIT_DAC_SRC];
            cfg_nxt.dac_code = b_dac[4:0];
        end
        else if (i_cmd_valid && c_code == CMD_READ && c_sub == SUB_FACTORY)
        begin
            rsp_valid_nxt = 1'b1;
            rsp_nxt = '0;
            rsp_nxt[BYTE_CODE*8 +: 8] = CMD_READ;
            rsp_nxt[BYTE_STATUS*8 +: 8] = ST_OK;
            rsp_nxt[BYTE_LEN*8 +: 8] = FACTORY_LEN;
            rsp_nxt[BYTE_DATA*8 +: 64] = FACTORY_SERIAL;
        end
        else if (i_cmd_valid && c_code == CMD_WRITE)
        begin
            rsp_valid_nxt = 1'b1;
            rsp_nxt = '0;
            rsp_nxt[BYTE_CODE*8 +: 8] = CMD_WRITE;
            if (c_sub > SUB_SERIAL)
            begin
                rsp_nxt[BYTE_STATUS*8 +: 8] = ST_UNSUP;
            end
            else if (cfg_r.security == FSCH_SEC_LOCK_A || cfg_r.security == FSCH_SEC_LOCK_B ||
                     (cfg_r.security == FSCH_SEC_PASSWORD && !i_unlocked)) // Lock ignores password
            begin
                rsp_nxt[BYTE_STATUS*8 +: 8] = ST_LOCKED;
            end
            else
            begin
                rsp_nxt[BYTE_STATUS*8 +: 8] = ST_OK;
                nv_we_nxt = 1'b1;
                nv_sub_nxt = c_sub;
                nv_data_nxt = i_cmd[REPORT_BITS-1:16];
                if (c_sub == SUB_CHIP)
                begin
                    cfg_nxt.serial_enum_en = c_flags[BIT_SER_EN];
                    cfg_nxt.rx_idle = c_flags[BIT_RX_IDLE];
                    cfg_nxt.tx_idle = c_flags[BIT_TX_IDLE];
                    cfg_nxt.i2c_idle = c_flags[BIT_I2C_IDLE];
                    cfg_nxt.sus_idle = c_flags[BIT_SUS_IDLE];
                    cfg_nxt.cfg_idle = c_flags[BIT_CFG_IDLE];
                    cfg_nxt.security = fsch_sec_t'(c_flags[1:0]);
                    cfg_nxt.clk_div = c_div[4:0];
                    cfg_nxt.dac_ref_level = c_dac[7:6];
                    cfg_nxt.dac_ref_vdd = c_dac[BIT_DAC_SRC];
                    cfg_nxt.dac_code = c_dac[4:0];
                end
            end
        end
    end

    // Indicator pins: idle level, inverted while active
    always_comb
    begin
        ind_nxt[0] = cfg_r.rx_idle ^ act_r.rx_busy;
        ind_nxt[1] = cfg_r.tx_idle ^ act_r.tx_busy;
        ind_nxt[2] = cfg_r.i2c_idle ^ (act_r.i2c_busy & act_r.i2c_pin_en);
        ind_nxt[3] = cfg_r.sus_idle ^ (act_r.suspended & act_r.sus_pin_en);
        ind_nxt[4] = cfg_r.cfg_idle ^ (act_r.configured & act_r.cfg_pin_en);
        ind_nxt[5] = 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            cfg_r <= '0;
            boot_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
            nv_we_r <= 1'b0;
            nv_sub_r <= 8'h00;
            nv_data_r <= '0;
            ind_r <= 6'h00;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            boot_r <= boot_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
            nv_we_r <= nv_we_nxt;
            nv_sub_r <= nv_sub_nxt;
            nv_data_r <= nv_data_nxt;
            ind_r <= ind_nxt;
        end
    end

    // Divided clock for the general purpose pin
    fsch_clkdiv u_clkdiv (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_en(i_clkout_en),
        .i_div(cfg_r.clk_div),
        .o_clk(clk_pin)
    );

    assign o_rsp_valid = rsp_valid_r;
    assign o_rsp = rsp_r;
    assign o_nv_we = nv_we_r;
    assign o_nv_sub = nv_sub_r;
    assign o_nv_data = nv_data_r;
    assign o_serial_enum_en = cfg_r.serial_enum_en;
    assign o_rx_indicator = ind_r[0];
    assign o_tx_indicator = ind_r[1];
    assign o_i2c_indicator = ind_r[2];
    assign o_suspend_indicator = ind_r[3];
    assign o_configured_indicator = ind_r[4];
    assign o_security = cfg_r.security;
    assign o_clk_out = clk_pin;
    assign o_dac_ref_level = cfg_r.dac_ref_level;
    assign o_dac_ref_vdd = cfg_r.dac_ref_vdd;
    assign o_dac_code = cfg_r.dac_code;
endmodule
`default_nettype wire

// [fsch_pkg.sv]
// Constants, types and command codes for the settings command handler.
// Assumes whole 64-byte reports are handed in and out as flat vectors.
package fsch_pkg;
    localparam int REPORT_BYTES = 64;
    localparam int REPORT_BITS = 512;
    localparam logic [7:0] CMD_READ = 8'hB0;
    localparam logic [7:0] CMD_WRITE = 8'hB1;
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_UNSUP = 8'h01;
    localparam logic [7:0] ST_LOCKED = 8'h03;
    localparam logic [7:0] SUB_CHIP = 8'h00;
    localparam logic [7:0] SUB_GP = 8'h01;
    localparam logic [7:0] SUB_MFR = 8'h02;
    localparam logic [7:0] SUB_PROD = 8'h03;
    localparam logic [7:0] SUB_SERIAL = 8'h04;
    localparam logic [7:0] SUB_FACTORY = 8'h05;
    localparam int BYTE_CODE = 0;
    localparam int BYTE_STATUS = 1;
    localparam int BYTE_LEN = 2;
    localparam int BYTE_DATA = 4;
    localparam int BYTE_FLAGS = 2;
    localparam int BYTE_CLKDIV = 3;
    localparam int BYTE_DAC = 4;
    localparam int BIT_SER_EN = 7;
    localparam int BIT_RX_IDLE = 6;
    localparam int BIT_TX_IDLE = 5;
    localparam int BIT_I2C_IDLE = 4;
    localparam int BIT_SUS_IDLE = 3;
    localparam int BIT_CFG_IDLE = 2;
    localparam int BIT_DAC_SRC = 5;
    localparam logic [7:0] FACTORY_LEN = 8'h08;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_CLKDIV = 8'h00;
    localparam logic [7:0] RST_DAC = 8'h00;
    localparam logic [4:0] DIV_ONE = 5'h01;
    typedef enum logic [1:0] {
        FSCH_SEC_OPEN = 2'b00,
        FSCH_SEC_PASSWORD = 2'b01,
        FSCH_SEC_LOCK_A = 2'b10,
        FSCH_SEC_LOCK_B = 2'b11
    } fsch_sec_t;
    typedef struct packed {
        logic serial_enum_en;
        logic rx_idle;
        logic tx_idle;
        logic i2c_idle;
        logic sus_idle;
        logic cfg_idle;
        fsch_sec_t security;
        logic [4:0] clk_div;
        logic [1:0] dac_ref_level;
        logic dac_ref_vdd;
        logic [4:0] dac_code;
    } fsch_cfg_t;
    typedef struct packed {
        logic rx_busy;
        logic tx_busy;
        logic i2c_busy;
        logic i2c_pin_en;
        logic suspended;
        logic sus_pin_en;
        logic configured;
        logic cfg_pin_en;
    } fsch_act_t;
endpackage

// [fsch_clkdiv.sv]
// Clock output divider producing a toggling pin level.
// Assumes one core clock; divide value taken in whole cycles.
`timescale 1ns/1ps
`default_nettype none
module fsch_clkdiv
    import fsch_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_en,
    input wire logic [4:0] i_div,
    output logic o_clk
);
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic out_r;
    logic out_nxt;

    // Count to the divide value, toggle on wrap
    always_comb
    begin
        cnt_nxt = cnt_r + DIV_ONE;
        out_nxt = out_r;
        if (!i_en)
        begin
            cnt_nxt = 5'h00;
            out_nxt = 1'b0;
        end
        else if (cnt_r + DIV_ONE >= i_div)
        begin
            cnt_nxt = 5'h00;
            out_nxt = ~out_r;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            cnt_r <= 5'h00;
            out_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign o_clk = out_r;
endmodule
`default_nettype wire

// [fsch_handler_chk.sv]
// Port checker for the settings command handler.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fsch_handler_chk
    import fsch_pkg::*;
#(
    parameter logic [63:0] FACTORY_SERIAL = 64'h3132333435363738
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_cmd_valid,
    input wire logic [REPORT_BITS-1:0] i_cmd,
    input wire logic i_unlocked,
    input wire logic i_rx_busy,
    input wire logic o_rsp_valid,
    input wire logic [REPORT_BITS-1:0] o_rsp,
    input wire logic o_nv_we,
    input wire logic o_serial_enum_en,
    input wire logic o_rx_indicator,
    input wire logic [1:0] o_security,
    input wire logic [1:0] o_dac_ref_level,
    input wire logic o_dac_ref_vdd,
    input wire logic [4:0] o_dac_code
);
    logic [1:0] up_r;
    logic [1:0] up_nxt;
    logic [23:0] cmd_r;
    // Edges since reset release, saturating
    always_comb
    begin
        up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
    end
    // Count and chip-settings bytes of the last report
    always_ff @(posedge i_core_clk)
    begin
        up_r <= i_rst_n ? up_nxt : 2'h0;
        cmd_r <= i_cmd[39:16];
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // Recognised requests, accepted writes and quiet stretches
    sequence rd_s;
        up_r > 2'h1 && i_cmd_valid && i_cmd[15:0] == 16'h05B0;
    endsequence
    sequence wr_s;
        up_r > 2'h1 && i_cmd_valid && i_cmd[7:0] == CMD_WRITE;
    endsequence
    sequence ok_s;
        wr_s ##0 (i_cmd[15:8] <= SUB_SERIAL && (o_security == 2'h0 || (o_security == 2'h1 && i_unlocked)));
    endsequence
    sequence quiet_s;
        (up_r == 2'h3 && !i_cmd_valid && $stable(i_rx_busy))[*5];
    endsequence
    a_read_head: assert property (rd_s |=> o_rsp_valid && o_rsp[31:0] == 32'h000800B0)
        else $error("serial reply header wrong");
    a_read_serial: assert property (rd_s |=> o_rsp[95:32] == FACTORY_SERIAL)
        else $error("serial reply string wrong");
    a_write_echo: assert property (wr_s |=> o_rsp_valid && o_rsp[7:0] == CMD_WRITE)
        else $error("write not answered");
    a_unsup_sub: assert property (wr_s ##0 i_cmd[15:8] > SUB_SERIAL |=> o_rsp[15:8] == ST_UNSUP && !o_nv_we)
        else $error("unknown sub-code not refused");
    a_store_write: assert property (ok_s |=> o_nv_we && o_rsp[15:8] == ST_OK)
        else $error("accepted write not stored");
    a_chip_apply: assert property (ok_s ##0 i_cmd[15:8] == SUB_CHIP |=> {o_serial_enum_en, o_security, o_dac_ref_level, o_dac_ref_vdd, o_dac_code} == {cmd_r[7], cmd_r[1:0], cmd_r[23:16]})
        else $error("chip settings not applied");
    a_locked_hold: assert property (wr_s ##0 ((o_security[1] || (o_security == 2'h1 && !i_unlocked)) && i_cmd[15:8] <= SUB_SERIAL) |=> o_rsp[15:8] == ST_LOCKED && !o_nv_we && $stable(o_security))
        else $error("locked write not refused");
    a_ignore_other: assert property (up_r > 2'h1 && !(i_cmd_valid && (i_cmd[7:0] == CMD_WRITE || i_cmd[15:0] == 16'h05B0)) |=> !o_rsp_valid && !o_nv_we)
        else $error("answer without request");
    a_rx_follow: assert property (quiet_s ##1 ($changed(i_rx_busy) && !i_cmd_valid) ##1 quiet_s |-> o_rx_indicator != $past(o_rx_indicator, 5))
        else $error("receive indicator did not follow");
endmodule
bind fsch_handler fsch_handler_chk #(.FACTORY_SERIAL(FACTORY_SERIAL)) u_chk (.i_core_clk, .i_rst_n,
    .i_cmd_valid, .i_cmd, .i_unlocked, .i_rx_busy, .o_rsp_valid, .o_rsp, .o_nv_we,
    .o_serial_enum_en, .o_rx_indicator, .o_security, .o_dac_ref_level, .o_dac_ref_vdd, .o_dac_code);
`default_nettype wire

// [fsch_host.sv]
// Host model: presents 64-byte command reports one edge at a time.
// Assumes tasks are called just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module fsch_host
    import fsch_pkg::*;
(
    input wire logic i_core_clk,
    output logic o_valid,
    output logic [REPORT_BITS-1:0] o_cmd
);
    // Idle lines: strobe low, data all ones
    initial
    begin
        o_valid = 1'b0;
        o_cmd = '1;
    end
    // Present one report across one rising edge; strobe and data stay driven until the next send or idle
    task automatic send(input logic [REPORT_BITS-1:0] r);
        o_valid = 1'b1;
        o_cmd = r;
        @(negedge i_core_clk);
    endtask
    // Release: data flips so no stale report lingers
    task automatic idle();
        o_valid = 1'b0;
        o_cmd = ~o_cmd;
        @(negedge i_core_clk);
    endtask
endmodule
`default_nettype wire

// [fsch_handler_tb.sv]
// Self-checking bench for the settings command handler.
// Assumes the host model sends reports; activity levels come from here.
`timescale 1ns/1ps
`default_nettype none
module fsch_handler_tb
    import fsch_pkg::*;
();
    localparam logic [63:0] FSER = 64'h0123456789ABCDEF; // Arbitrary serial
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_unlocked = 1'b1;
    logic i_clkout_en = 1'b0;
    logic i_cmd_valid, o_rsp_valid, o_nv_we, o_clk_out, lvl;
    logic [REPORT_BITS-1:0] i_cmd, o_rsp;
    logic [23:0] i_nv_boot, cfg;
    logic [7:0] o_nv_sub, s;
    logic [495:0] o_nv_data;
    logic [10:0] sets;
    logic [4:0] ind;
    logic [31:0] r;
    logic [31:0] rs = 32'h0000A453;
    fsch_act_t act = '0;
    int errors = 0;
    int n_checks = 0;
    int k;
    always #2.5 i_core_clk = ~i_core_clk;
    fsch_host HOST (.i_core_clk, .o_valid(i_cmd_valid), .o_cmd(i_cmd));
    fsch_handler #(.FACTORY_SERIAL(FSER)) DUT (.i_core_clk, .i_rst_n, .i_cmd_valid, .i_cmd,
        .i_nv_boot, .i_unlocked, .i_rx_busy(act.rx_busy), .i_tx_busy(act.tx_busy),
        .i_i2c_busy(act.i2c_busy), .i_i2c_pin_en(act.i2c_pin_en), .i_suspended(act.suspended),
        .i_sus_pin_en(act.sus_pin_en), .i_configured(act.configured), .i_cfg_pin_en(act.cfg_pin_en),
        .i_clkout_en, .o_rsp_valid, .o_rsp, .o_nv_we, .o_nv_sub, .o_nv_data,
        .o_serial_enum_en(sets[10]), .o_rx_indicator(ind[4]), .o_tx_indicator(ind[3]),
        .o_i2c_indicator(ind[2]), .o_suspend_indicator(ind[1]), .o_configured_indicator(ind[0]),
        .o_security(sets[9:8]), .o_clk_out, .o_dac_ref_level(sets[7:6]),
        .o_dac_ref_vdd(sets[5]), .o_dac_code(sets[4:0]));
    // Xorshift source and random reports
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    function automatic logic [511:0] rrep();
        logic [511:0] v;
        for (int j = 0; j < 16; j++)
            v[32*j +: 32] = rnd();
        return v;
    endfunction
    // Indicator levels: idle bit flipped while active
    function automatic logic [4:0] exp_ind(input logic [7:0] f, input fsch_act_t a);
        return f[6:2] ^ {a.rx_busy, a.tx_busy, a.i2c_busy & a.i2c_pin_en,
            a.suspended & a.sus_pin_en, a.configured & a.cfg_pin_en};
    endfunction
    task automatic chk(input string nm, input logic [511:0] e, input logic [511:0] g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("FAIL %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // Write request with status worked out from sub-code and lock state
    task automatic wr(input logic [7:0] sub, input logic [7:0] f);
        logic [511:0] c;
        logic [7:0] st;
        c = rrep();
        c[23:0] = {f, sub, CMD_WRITE};
        st = (cfg[1] || (cfg[1:0] == 2'h1 && !i_unlocked)) ? ST_LOCKED : ST_OK;
        st = (sub > SUB_SERIAL) ? ST_UNSUP : st;
        HOST.send(c);
        chk("response", {1'b1, st, CMD_WRITE}, {o_rsp_valid, o_rsp[15:0]});
        chk("store strobe", st == ST_OK, o_nv_we);
        if (st == ST_OK)
            chk("store data", {c[15:8], c[511:16]}, {o_nv_sub, o_nv_data});
        if (st == ST_OK && sub == SUB_CHIP)
            cfg = c[39:16];
        chk("settings", {cfg[7], cfg[1:0], cfg[23:16]}, sets);
    endtask
    task automatic rd();
        logic [511:0] c;
        c = rrep();
        c[15:0] = {SUB_FACTORY, CMD_READ};
        HOST.send(c);
        chk("serial reply", {1'b1, FSER, 8'h00, FACTORY_LEN, ST_OK, CMD_READ}, {o_rsp_valid, o_rsp[95:0]});
    endtask
    // Report with an unknown code, or a read of another sub-code
    task automatic ign();
        logic [511:0] c;
        c = rrep();
        c[7:0] = c[8] ? CMD_READ : {1'b0, c[6:0]};
        if (c[15:8] == SUB_FACTORY)
            c[15:8] = SUB_CHIP;
        HOST.send(c);
        chk("ignored", 2'b00, {o_rsp_valid, o_nv_we});
    endtask
    // Reset pulse, then settings must come from the boot image
    task automatic rst_boot(input int n);
        i_rst_n = 1'b0;
        repeat (n) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_core_clk);
        cfg = i_nv_boot;
        chk("boot settings", {cfg[7], cfg[1:0], cfg[23:16]}, sets);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #100000;
        errors++;
        summarize();
    end
    // Main sequence
    initial
    begin
        r = rnd();
        i_nv_boot = {r[23:2], 2'b00};
        rst_boot(10);
        i_clkout_en = 1'b1;
        repeat (70) @(negedge i_core_clk);
        repeat (2)
        begin
            lvl = o_clk_out;
            k = 0;
            while (o_clk_out === lvl && k < 40)
            begin
                @(negedge i_core_clk);
                k++;
            end
        end
        chk("clock half period", (cfg[12:8] == 5'h00) ? 1 : cfg[12:8], k);
        for (int i = 0; i < 24; i++)
        begin
            r = rnd();
            if (r[9])
                rd();
            else
                ign();
            i_unlocked = r[8];
            s = (i < 8) ? i[7:0] : (i % 3 == 0) ? SUB_CHIP : r[7:0];
            wr(s, {r[23:18], i[1:0]});
            HOST.idle();
            repeat (6) @(negedge i_core_clk);
            act = fsch_act_t'(r[31:24]);
            repeat (8) @(negedge i_core_clk);
            chk("indicators", exp_ind(cfg[7:0], act), ind);
        end
        rst_boot(2);
        i_unlocked = 1'b1;
        wr(SUB_CHIP, 8'h01);
        i_unlocked = 1'b0;
        wr(SUB_MFR, 8'h00);
        wr(SUB_CHIP, 8'h00);
        i_unlocked = 1'b1;
        wr(SUB_CHIP, 8'h00);
        wr(8'hFF, 8'h00);
        wr(SUB_CHIP, 8'h02);
        wr(SUB_GP, 8'h00);
        HOST.idle();
        summarize();
    end
endmodule
`default_nettype wire
